// >>> core/phgp_map.svh
// Register offsets, reset values and pin map constants of the port H block
`ifndef PHGP_MAP_SVH
`define PHGP_MAP_SVH

// Register offsets (3-bit word index)
`define PHGP_OFS_PIN_DATA      3'h0
`define PHGP_OFS_LATCH         3'h1
`define PHGP_OFS_DIRECTION     3'h2
`define PHGP_OFS_SEG_ENABLE    3'h3
`define PHGP_OFS_ANA_SEL_MID   3'h4
`define PHGP_OFS_ANA_SEL_UPPER 3'h5
`define PHGP_OFS_PIN_DRIVEN    3'h6

// Reset values
`define PHGP_RST_LATCH         8'h00
`define PHGP_RST_DIRECTION     8'hff
`define PHGP_RST_SEG_ENABLE    8'h00
`define PHGP_RST_ANA_SEL_MID   8'hff
`define PHGP_RST_ANA_SEL_UPPER 8'hff
`define PHGP_RST_READ_DATA     8'h00

// Segment-enable bank bit per pin, 3 bits a pin, pin 7 on top (bank bit n drives segment 40+n)
`define PHGP_SEG_BIT_MAP       24'h688977
// Analog-select bit per pin, 3 bits a pin, pin 7 on top
`define PHGP_ANA_BIT_MAP       24'hfac977
// Pins whose analog bit sits in the upper select register (channels 20..23)
`define PHGP_ANA_IN_UPPER      8'h0f
// Pins shared with capture-compare and enhanced-PWM outputs
`define PHGP_ALT_PIN_LO        4
`define PHGP_ALT_PIN_HI        5

`endif

// >>> core/phgp_pkg.sv
// Types shared by the port H block
package phgp_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } phgp_bus_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } phgp_pad_t;

  typedef struct packed {
    logic ccu9_out;
    logic ccu9_en;
    logic ccu8_out;
    logic ccu8_en;
    logic pwm3c_out;
    logic pwm3c_en;
    logic pwm3b_out;
    logic pwm3b_en;
    logic pwm3_shutdown;
    logic pwm3_shutdown_tri;
  } phgp_alt_in_t;

  typedef struct packed {
    logic ccu9_capture;
    logic ccu8_capture;
    logic cmp2_in_c;
    logic cmp2_in_d;
  } phgp_alt_out_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] seg_en;
    logic [7:0] ana_mid;
    logic [7:0] ana_upper;
    logic [7:0] rdata;
    logic [7:0] sync1;
    logic [7:0] sync2;
    phgp_pad_t  pad;
    logic [7:0] ana_conn_mid;
    logic [7:0] ana_conn_upper;
    phgp_alt_out_t alt;
  } phgp_state_t;

endpackage

// >>> core/phgp_pin_mux.sv
// One pin of port H: function priority and pad drive
`timescale 1ns/10ps
`default_nettype none

module phgp_pin_mux (
  // Configuration
  input  wire logic seg_en,
  input  wire logic seg_val,
  input  wire logic dir,
  input  wire logic latch,
  input  wire logic ana_sel,
  // Peripheral output
  input  wire logic alt_en,
  input  wire logic alt_val,
  input  wire logic alt_tri,
  // Pad side
  output logic      pad_o,
  output logic      pad_oe_n,
  output logic      ana_conn,
  output logic      dig_in_ok
);

  always_comb begin
    if (seg_en) begin
      pad_o    = seg_val;    // see RL4
      pad_oe_n = 1'b0;
    end else if (dir) begin
      pad_o    = 1'b0;       // see RL2
      pad_oe_n = 1'b1;
    end else if (alt_en) begin
      pad_o    = alt_val;    // see RL8
      pad_oe_n = alt_tri;    // see RL9
    end else begin
      pad_o    = latch;      // see RL2
      pad_oe_n = 1'b0;
    end
    ana_conn  = ana_sel & dir & ~seg_en; // see RL6
    dig_in_ok = ~seg_en;                 // see RL7
  end

endmodule // phgp_pin_mux

`default_nettype wire

// >>> core/phgp_port.sv
// Port H general-purpose I/O with pin sharing and register port
//
// Summary of operation
// RL1 - Eight pins, each set to input or output on its own by its direction bit.
// RL2 - Direction 0 drives the pin from its latch bit; direction 1 makes it an input read back on a port read.
// RL3 - Writing the port data register writes the latch just as a latch write does, so clearing either clears it.
// RL4 - An enabled segment drive owns its pin and blocks every other function of it; a port data read still returns the pin's synchronised level.
// RL5 - Pins 0..3 carry segments 47..44 and pins 4, 5 carry segments 40, 41.
// RL6 - Pins 0..3 carry analog channels 23..20 and pins 4, 5 carry channels 12, 13, used with direction 1.
// RL7 - Analog selection is the reset default and leaves the digital input path working.
// RL8 - With direction 0, units 9 and 8 compare outputs drive pins 4 and 5; with direction 1 the pins feed their captures.
// RL9 - Enhanced-PWM 3 outputs C and B drive pins 4 and 5 with direction 0 and may float during shutdown.
// RL10 - Comparator 2 inputs C and D follow pins 4 and 5 whatever the direction bit.
// RL11 - The port exists only in the large package variant; without it the block is inert.
// RL12 - Software clears a pin's analog select before using it for digital work.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "phgp_map.svh"

module phgp_port #(
  parameter int  WIDTH        = 8,
  parameter bit  PORT_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // Register port
  input  wire phgp_pkg::phgp_bus_req_t bus_req,
  output logic [7:0]                bus_rdata,
  // Pads
  input  wire logic [WIDTH-1:0]     pad_in,
  output phgp_pkg::phgp_pad_t       pad,
  // Segment drive values, index n is segment 40+n
  input  wire logic [7:0]           lcd_seg_val,
  // Capture-compare and enhanced-PWM units
  input  wire phgp_pkg::phgp_alt_in_t  alt_in,
  output phgp_pkg::phgp_alt_out_t   alt_out,
  // Analog switch enables: channels 8..15 and 16..23
  output logic [7:0]                ana_conn_mid,
  output logic [7:0]                ana_conn_upper
);
  import phgp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin map
  localparam logic [23:0] SEG_MAP   = `PHGP_SEG_BIT_MAP;
  localparam logic [23:0] ANA_MAP   = `PHGP_ANA_BIT_MAP;
  localparam logic [7:0]  ANA_UPPER = `PHGP_ANA_IN_UPPER;

  phgp_state_t state_q;
  phgp_state_t state_d;

  logic [WIDTH-1:0] mux_o;
  logic [WIDTH-1:0] mux_oe_n;
  logic [WIDTH-1:0] mux_ana;
  logic [WIDTH-1:0] mux_dig_ok;
  logic [WIDTH-1:0] pin_seg_en;
  logic [WIDTH-1:0] pin_seg_val;
  logic [WIDTH-1:0] pin_ana_sel;
  logic [WIDTH-1:0] pin_alt_en;
  logic [WIDTH-1:0] pin_alt_val;
  logic [WIDTH-1:0] pin_alt_tri;

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin function selection
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    localparam logic [2:0] SEG_BIT = SEG_MAP[3*i +: 3];
    localparam logic [2:0] ANA_BIT = ANA_MAP[3*i +: 3];

    assign pin_seg_en[i]  = state_q.seg_en[SEG_BIT];           // see RL5
    assign pin_seg_val[i] = lcd_seg_val[SEG_BIT];              // see RL5
    assign pin_ana_sel[i] = ANA_UPPER[i] ? state_q.ana_upper[ANA_BIT]
                                         : state_q.ana_mid[ANA_BIT]; // see RL6

    if (i == `PHGP_ALT_PIN_LO) begin : g_alt_lo
      assign pin_alt_en[i]  = alt_in.pwm3c_en | alt_in.ccu9_en;  // see RL8
      assign pin_alt_val[i] = alt_in.pwm3c_en ? alt_in.pwm3c_out : alt_in.ccu9_out;
      assign pin_alt_tri[i] = alt_in.pwm3c_en & alt_in.pwm3_shutdown
                              & alt_in.pwm3_shutdown_tri;        // see RL9
    end else if (i == `PHGP_ALT_PIN_HI) begin : g_alt_hi
      assign pin_alt_en[i]  = alt_in.pwm3b_en | alt_in.ccu8_en;  // see RL8
      assign pin_alt_val[i] = alt_in.pwm3b_en ? alt_in.pwm3b_out : alt_in.ccu8_out;
      assign pin_alt_tri[i] = alt_in.pwm3b_en & alt_in.pwm3_shutdown
                              & alt_in.pwm3_shutdown_tri;        // see RL9
    end else begin : g_alt_none
      assign pin_alt_en[i]  = 1'b0;
      assign pin_alt_val[i] = 1'b0;
      assign pin_alt_tri[i] = 1'b0;
    end

    phgp_pin_mux u_mux (
      .seg_en    (pin_seg_en[i]),
      .seg_val   (pin_seg_val[i]),
      .dir       (state_q.dir[i]),
      .latch     (state_q.latch[i]),
      .ana_sel   (pin_ana_sel[i]),
      .alt_en    (pin_alt_en[i]),
      .alt_val   (pin_alt_val[i]),
      .alt_tri   (pin_alt_tri[i]),
      .pad_o     (mux_o[i]),
      .pad_oe_n  (mux_oe_n[i]),
      .ana_conn  (mux_ana[i]),
      .dig_in_ok (mux_dig_ok[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_d = state_q;

    // Pad input synchroniser
    state_d.sync1 = pad_in;
    state_d.sync2 = state_q.sync1;

    // Register writes
    if (bus_req.wr && PORT_PRESENT) begin
      case (bus_req.addr)
        `PHGP_OFS_PIN_DATA:      state_d.latch     = bus_req.wdata; // see RL3
        `PHGP_OFS_LATCH:         state_d.latch     = bus_req.wdata; // see RL3
        `PHGP_OFS_DIRECTION:     state_d.dir       = bus_req.wdata; // see RL1
        `PHGP_OFS_SEG_ENABLE:    state_d.seg_en    = bus_req.wdata;
        `PHGP_OFS_ANA_SEL_MID:   state_d.ana_mid   = bus_req.wdata;
        `PHGP_OFS_ANA_SEL_UPPER: state_d.ana_upper = bus_req.wdata;
        default: ;
      endcase
    end

    // Register reads, data valid in the following cycle
    state_d.rdata = `PHGP_RST_READ_DATA;
    if (bus_req.rd && PORT_PRESENT) begin
      case (bus_req.addr)
        `PHGP_OFS_PIN_DATA:      state_d.rdata = state_q.sync2;  // see RL2
        `PHGP_OFS_LATCH:         state_d.rdata = state_q.latch;
        `PHGP_OFS_DIRECTION:     state_d.rdata = state_q.dir;
        `PHGP_OFS_SEG_ENABLE:    state_d.rdata = state_q.seg_en;
        `PHGP_OFS_ANA_SEL_MID:   state_d.rdata = state_q.ana_mid;
        `PHGP_OFS_ANA_SEL_UPPER: state_d.rdata = state_q.ana_upper;
        `PHGP_OFS_PIN_DRIVEN:    state_d.rdata = ~state_q.pad.oe_n;
        default:                 state_d.rdata = `PHGP_RST_READ_DATA;
      endcase
    end

    // Pad drive, inert when the port is absent
    if (PORT_PRESENT) begin
      state_d.pad.out  = mux_o;
      state_d.pad.oe_n = mux_oe_n;
    end else begin
      state_d.pad.out  = '0;                                     // see RL11
      state_d.pad.oe_n = '1;
    end

    // Analog switch enables
    state_d.ana_conn_mid   = '0;
    state_d.ana_conn_upper = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (PORT_PRESENT && mux_ana[i]) begin
        if (ANA_UPPER[i]) begin
          state_d.ana_conn_upper[ANA_MAP[3*i +: 3]] = 1'b1;      // see RL6
        end else begin
          state_d.ana_conn_mid[ANA_MAP[3*i +: 3]] = 1'b1;        // see RL6
        end
      end
    end

    // Peripheral inputs taken from the synchronised pin level
    state_d.alt.ccu9_capture = PORT_PRESENT && state_q.dir[`PHGP_ALT_PIN_LO]
                               && mux_dig_ok[`PHGP_ALT_PIN_LO]
                               && state_q.sync2[`PHGP_ALT_PIN_LO];  // see RL8
    state_d.alt.ccu8_capture = PORT_PRESENT && state_q.dir[`PHGP_ALT_PIN_HI]
                               && mux_dig_ok[`PHGP_ALT_PIN_HI]
                               && state_q.sync2[`PHGP_ALT_PIN_HI];  // see RL8
    state_d.alt.cmp2_in_c    = PORT_PRESENT && mux_dig_ok[`PHGP_ALT_PIN_LO]
                               && state_q.sync2[`PHGP_ALT_PIN_LO];  // see RL10
    state_d.alt.cmp2_in_d    = PORT_PRESENT && mux_dig_ok[`PHGP_ALT_PIN_HI]
                               && state_q.sync2[`PHGP_ALT_PIN_HI];  // see RL10
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q.latch          <= `PHGP_RST_LATCH;
      state_q.dir            <= `PHGP_RST_DIRECTION;
      state_q.seg_en         <= `PHGP_RST_SEG_ENABLE;
      state_q.ana_mid        <= `PHGP_RST_ANA_SEL_MID;              // see RL7
      state_q.ana_upper      <= `PHGP_RST_ANA_SEL_UPPER;            // see RL7
      state_q.rdata          <= `PHGP_RST_READ_DATA;
      state_q.sync1          <= '0;
      state_q.sync2          <= '0;
      state_q.pad.out        <= '0;
      state_q.pad.oe_n       <= '1;
      state_q.ana_conn_mid   <= '0;
      state_q.ana_conn_upper <= '0;
      state_q.alt            <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign bus_rdata      = state_q.rdata;
  assign pad            = state_q.pad;
  assign alt_out        = state_q.alt;
  assign ana_conn_mid   = state_q.ana_conn_mid;
  assign ana_conn_upper = state_q.ana_conn_upper;

endmodule // phgp_port

`default_nettype wire

// >>> verification/phgp_port_monitor.sv
// Port-level checks of the port H block
`timescale 1ns/10ps
`default_nettype none

module phgp_port_monitor #(
  parameter int WIDTH = 8
) (
  input wire logic                    sys_clk,
  input wire logic                    rstn,
  input wire phgp_pkg::phgp_bus_req_t bus_req,
  input wire logic [7:0]              bus_rdata,
  input wire logic [WIDTH-1:0]        pad_in,
  input wire phgp_pkg::phgp_pad_t     pad,
  input wire phgp_pkg::phgp_alt_out_t alt_out,
  input wire logic [7:0]              ana_conn_mid,
  input wire logic [7:0]              ana_conn_upper
);
  import phgp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_rd_idle; !bus_req.rd |=> bus_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_dir_back;
    bus_req.wr && bus_req.addr == 3'h2 ##1 bus_req.rd && bus_req.addr == 3'h2 |=> bus_rdata == $past(bus_req.wdata, 2);
  endproperty
  a_dir_back: assert property (p_dir_back) else $error("direction readback wrong");
  property p_port_wr;
    bus_req.wr && bus_req.addr == 3'h0 ##1 bus_req.rd && bus_req.addr == 3'h1 |=> bus_rdata == $past(bus_req.wdata, 2);
  endproperty
  a_port_wr: assert property (p_port_wr) else $error("port write missed latch");
  property p_driven; bus_req.rd && bus_req.addr == 3'h6 ##1 $stable(pad.oe_n) |-> bus_rdata == ~pad.oe_n; endproperty
  a_driven: assert property (p_driven) else $error("driven status wrong");
  property p_unmapped; bus_req.rd && bus_req.addr == 3'h7 |=> bus_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ana_drv;
    ((~pad.oe_n[3:0]) & {ana_conn_upper[4], ana_conn_upper[5], ana_conn_upper[6], ana_conn_upper[7]}) == 4'h0;
  endproperty
  a_ana_drv: assert property (p_ana_drv) else $error("analog switch on a driven pin");
  property p_ana_unused; ana_conn_upper[3:0] == 4'h0 && ana_conn_mid[3:0] == 4'h0; endproperty
  a_ana_unused: assert property (p_ana_unused) else $error("foreign analog channel enabled");
  property p_cmp;
    $stable(pad_in[4]) [*5] ##0 pad.oe_n[4] |-> alt_out.cmp2_in_c == pad_in[4];
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator input not following pin");
endmodule // phgp_port_monitor

bind phgp_port phgp_port_monitor #(.WIDTH(WIDTH)) mon_u (.sys_clk, .rstn, .bus_req, .bus_rdata, .pad_in, .pad,
  .alt_out, .ana_conn_mid, .ana_conn_upper);

`default_nettype wire

// >>> verification/phgp_port_tb.sv
// Self-checking bench for the port H block
`timescale 1ns/10ps
`default_nettype none

module phgp_port_tb;
  import phgp_pkg::*;
  logic          sys_clk;
  logic          rstn;
  phgp_bus_req_t bus_req;
  logic [7:0]    bus_rdata;
  logic [7:0]    ext;
  wire  [7:0]    pad_in;
  phgp_pad_t     pad;
  logic [7:0]    lcd_seg_val;
  phgp_alt_in_t  alt_in;
  phgp_alt_out_t alt_out;
  logic [7:0]    ana_conn_mid;
  logic [7:0]    ana_conn_upper;
  int            n_mismatch;
  int            compares;
  int            cyc = 0;
  logic [7:0]    rst_tab [8];

  // Driven bits show the pad value on the wire
  assign pad_in = (pad.oe_n & ext) | (~pad.oe_n & pad.out);

  phgp_port #(.WIDTH(8), .PORT_PRESENT(1'b1)) dut_u (.sys_clk, .rstn, .bus_req, .bus_rdata, .pad_in, .pad,
    .lcd_seg_val, .alt_in, .alt_out, .ana_conn_mid, .ana_conn_upper);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk(bus_rdata, exp);
  endtask

  task automatic settle(input int n);
    @(posedge sys_clk);
    bus_req <= '0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic put_alt(input logic [9:0] v);
    @(posedge sys_clk);
    alt_in <= v;
  endtask

  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    rstn = 1'b0;
    bus_req = '0;
    ext = 8'h5a;
    lcd_seg_val = 8'h00;
    alt_in = '0;
    n_mismatch = 0;
    compares = 0;
    rst_tab = '{8'h5a, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    // Reset state, analog default with digital input alive
    settle(4);
    chk(pad.oe_n, 8'hff);
    chk(ana_conn_upper, 8'hf0);
    chk(ana_conn_mid, 8'hf0);
    foreach (rst_tab[i]) rdc(3'(i), rst_tab[i]);
    $display("test 1 done");
    // Latch through both registers, then drive pins 4 and 5
    wr(3'h0, 8'ha5);
    rdc(3'h1, 8'ha5);
    wr(3'h1, 8'hff);
    wr(3'h0, 8'h00);
    rdc(3'h1, 8'h00);
    wr(3'h1, 8'h20);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    wr(3'h2, 8'hcf);
    rdc(3'h2, 8'hcf);
    settle(2);
    chk(pad.oe_n, 8'hcf);
    chk(pad.out & 8'h30, 8'h20);
    chk(ana_conn_mid | ana_conn_upper, 8'h00);
    rdc(3'h6, 8'h30);
    settle(3);
    rdc(3'h0, 8'h6a);
    $display("test 2 done");
    // Peripherals on pins 4 and 5
    put_alt(10'b11_01_00_00_00);
    settle(2);
    chk(pad.out & 8'h30, 8'h10);
    put_alt(10'b11_01_01_11_00);
    settle(2);
    chk(pad.out & 8'h30, 8'h20);
    put_alt(10'b11_01_01_11_11);
    settle(4);
    chk(pad.oe_n & 8'h30, 8'h30);
    chk(8'(alt_out), 8'h02);
    wr(3'h2, 8'hff);
    settle(5);
    chk(8'(alt_out), 8'h0a);
    $display("test 3 done");
    // Segments override direction on pins 0 and 4
    @(posedge sys_clk);
    lcd_seg_val <= 8'h80;
    wr(3'h3, 8'h81);
    settle(2);
    chk(~pad.oe_n & 8'h11, 8'h11);
    chk(pad.out & 8'h11, 8'h01);
    $display("test 4 done");
    stop_test();
  end
endmodule // phgp_port_tb

`default_nettype wire
